// file: hw/occd_pkg.sv
// occd_pkg: constants for the oscillator control and clock divider block
// assumes an avalon-mm slave with 32-bit data, one register per word
// Notes on behaviour
// - monitor on plus lock bit freezes selections
// - monitor off means selections never locked
// - pll lock reads one when locked/timer done
// - pll lock zero during switch, non-pll modes
// - clock fail flag set on monitor detected failure
// - drive bit set forces high-power secondary oscillator
// - digital secondary input makes drive bit moot
// - secondary enable bit turns oscillator on/off
// - switch bit requests switch, cleared when complete
// - recover-on-interrupt clears ratio_field_a enable on interrupt
// - ratio_field_a codes 0..7 give 1:1 to 1:128
// - ratio_field_a enable off forces 1:1 ratio
// - fast rc sources divide 8 MHz by table
// - source 110 divides 500 kHz same table
package occd_pkg;
    // register byte offsets
    localparam logic [3:0] OCCD_OSC_CTRL_OFS  = 4'h0; // oscillator_control
    localparam logic [3:0] OCCD_CLK_DIV_OFS   = 4'h4; // clock_divider
    localparam logic [3:0] OCCD_IRQ_STAT_OFS  = 4'h8; // sticky status, ro
    localparam logic [3:0] OCCD_IRQ_EN_OFS    = 4'hc; // interrupt enables
    localparam logic [4:0] OCCD_IRQ_CLR_OFS   = 5'h10; // write-one clear
    // oscillator_control field positions
    localparam int OCCD_SW_EN_BIT    = 0;
    localparam int OCCD_SEC_EN_BIT   = 1;
    localparam int OCCD_SEC_DRV_BIT  = 2;
    localparam int OCCD_FAIL_BIT     = 3;
    localparam int OCCD_PLL_LOCK_BIT = 5;
    localparam int OCCD_SEL_LOCK_BIT = 7;
    localparam int OCCD_NEW_SRC_LSB  = 8;
    localparam int OCCD_CUR_SRC_LSB  = 12;
    // clock_divider field positions
    localparam int OCCD_RC_DIV_LSB   = 8;
    localparam int OCCD_RATIO_FIELD_A_EN_BIT  = 11;
    localparam int OCCD_RATIO_FIELD_A_LSB     = 12;
    localparam int OCCD_RECOVER_BIT  = 15;
    // status bit positions
    localparam int OCCD_ST_FAIL_BIT  = 0;
    localparam int OCCD_ST_SWDN_BIT  = 1;
    localparam int OCCD_ST_RCVR_BIT  = 2;
    localparam int OCCD_ST_W         = 3;
    // reset values; postscaler default is divide-by-2
    localparam logic [15:0] OCCD_CLK_DIV_RST = 16'h0100;
    localparam logic [2:0]  OCCD_RC_DIV_RST  = 3'h1;
    // source codes
    localparam logic [2:0] OCCD_SRC_FASTRC     = 3'h7;
    localparam logic [2:0] OCCD_SRC_FASTRC_PLL = 3'h1;
    localparam logic [2:0] OCCD_SRC_LPRC       = 3'h6;
    // pll start-up timer, in microseconds, and its cycle count at 20 MHz
    localparam int OCCD_CLK_MHZ      = 20;
    localparam int OCCD_PLL_START_US = 2;
    localparam int OCCD_PLL_START_CYC = OCCD_PLL_START_US * OCCD_CLK_MHZ;
    // clock switch settle time in cycles
    localparam int OCCD_SWITCH_CYC   = 4;
    // switch sequencer states
    typedef enum logic [1:0] {
        OCCD_ST_IDLE   = 2'b00,
        OCCD_ST_SWITCH = 2'b01,
        OCCD_ST_DONE   = 2'b10
    } occd_state_e;
    // divide exponent for a 3-bit postscaler code; code 7 is /256
    function automatic logic [3:0] occd_rc_shift(input logic [2:0] code);
        return (code == 3'h7) ? 4'h8 : {1'b0, code};
    endfunction
endpackage

// file: hw/occd_div_if.sv
// occd_div_if: ratio selections passed to the divider counter
// assumes one sys_clk domain on both sides
`timescale 1ns/100ps
interface occd_div_if;
    logic [3:0] shift;   // divide by 2**shift
    logic       tick;    // one-cycle enable at the divided rate
    modport ctrl (output shift, input tick);
    modport div  (input shift, output tick);
endinterface

// file: hw/occd_divider.sv
// occd_divider: free-running counter giving a divided-rate tick
// assumes shift is stable, set by the control block on sys_clk
`timescale 1ns/100ps
module occd_divider
    import occd_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset_n,
    occd_div_if.div   dv
);
    typedef struct packed {
        logic [7:0] cnt;   // running count
        logic       tick;  // registered tick
    } occd_divst_s;
    occd_divst_s st_q;
    occd_divst_s st_d;
    logic [7:0]  lim;      // last count for this ratio
    // limit from the exponent; shift 0 ticks every cycle
    always_comb begin
        lim = 8'((9'h1 << dv.shift) - 9'h1);
    end
    // count and wrap
    always_comb begin
        st_d = st_q;
        if (st_q.cnt >= lim) begin
            st_d.cnt  = 8'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt  = st_q.cnt + 8'h01;
            st_d.tick = 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign dv.tick = st_q.tick;
endmodule

// file: hw/occd_top.sv
// occd_top: oscillator control low and high bytes and clock divider register
// assumes avalon-mm master on sys_clk; pins from analog come in async
`timescale 1ns/100ps
module occd_top
    import occd_pkg::*;
#(
    parameter int PLL_START_CYC = OCCD_PLL_START_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // configuration and event inputs
    input  wire logic        failsafe_monitor_config_bit,
    input  wire logic        secondary_osc_source_config,
    input  wire logic [2:0]  initial_source_config,
    input  wire logic        pll_locked_pin,
    input  wire logic        clock_fail_pin,
    input  wire logic        cpu_interrupt,
    // control outputs
    output logic             secondary_osc_on,
    output logic             secondary_osc_high_power,
    output logic [2:0]       current_source_field,
    output logic [3:0]       periph_ratio_shift,
    output logic [3:0]       rc_post_shift,
    output logic             rc_post_tick,
    output logic             irq
);
    // all block state
    typedef struct packed {
        logic [1:0]  lk_sync;    // pll lock synchroniser
        logic [1:0]  fail_sync;  // clock fail synchroniser
        logic        fail_prev;  // edge detect of synced fail
        logic        strap_done; // initial source captured
        logic [2:0]  cur_src;    // current source field
        logic [2:0]  new_src;    // new source field
        logic        sel_lock;   // selection lock bit
        logic        fail_flag;  // clock fail flag
        logic        sec_drv;    // secondary drive bit
        logic        sec_en;     // secondary enable bit
        logic        sw_en;      // switch enable bit
        logic        recover;    // recover on interrupt
        logic [2:0]  ratio_field_a;       // ratio field
        logic        ratio_field_a_en;    // ratio_field_a enable bit
        logic [2:0]  rc_div;     // rc postscaler field
        logic [15:0] pll_cnt;    // start-up timer
        logic        pll_ok;     // timer satisfied
        logic [3:0]  sw_cnt;     // switch settle count
        occd_state_e state;      // switch sequencer
        logic [OCCD_ST_W-1:0] stat;  // sticky status
        logic [OCCD_ST_W-1:0] en;    // interrupt enables
        logic [31:0] rdata;      // registered read data
        logic        ack;        // answer cycle
    } occd_st_s;
    occd_st_s   st_q;
    occd_st_s   st_d;
    occd_div_if dvi ();
    logic       wr_hit;          // write accepted this cycle
    logic       rd_hit;          // read accepted this cycle
    logic       pll_mode;        // current source uses the pll
    logic       sel_frozen;      // selections locked
    logic [15:0] osc_word;       // oscillator_control read view
    logic [15:0] div_word;       // clock_divider read view
    logic [OCCD_ST_W-1:0] ev;    // events this cycle
    // one wait cycle, then answer: keeps reads registered;
    // writes land on the answering edge, as the master sees it
    assign wr_hit = avs_write && st_q.ack;
    assign rd_hit = avs_read && !st_q.ack;
    assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
    assign pll_mode = (st_q.cur_src == OCCD_SRC_FASTRC_PLL);
    // lock only counts while the monitor is on
    assign sel_frozen = failsafe_monitor_config_bit && st_q.sel_lock;
    // register read views; reserved bits read zero
    always_comb begin
        osc_word = '0;
        osc_word[OCCD_CUR_SRC_LSB +: 3] = st_q.cur_src;
        osc_word[OCCD_NEW_SRC_LSB +: 3] = st_q.new_src;
        osc_word[OCCD_SEL_LOCK_BIT]     = st_q.sel_lock;
        // forced low in switch or non-pll mode
        osc_word[OCCD_PLL_LOCK_BIT]     = st_q.pll_ok && pll_mode
                                          && (st_q.state == OCCD_ST_IDLE);
        osc_word[OCCD_FAIL_BIT]         = st_q.fail_flag;
        osc_word[OCCD_SEC_DRV_BIT]      = st_q.sec_drv;
        osc_word[OCCD_SEC_EN_BIT]       = st_q.sec_en;
        osc_word[OCCD_SW_EN_BIT]        = st_q.sw_en;
        div_word = '0;
        div_word[OCCD_RECOVER_BIT]      = st_q.recover;
        div_word[OCCD_RATIO_FIELD_A_LSB +: 3]    = st_q.ratio_field_a;
        div_word[OCCD_RATIO_FIELD_A_EN_BIT]      = st_q.ratio_field_a_en;
        div_word[OCCD_RC_DIV_LSB +: 3]  = st_q.rc_div;
    end
    // next state of everything
    always_comb begin
        st_d = st_q;
        ev   = '0;
        st_d.ack = (avs_read || avs_write) && !st_q.ack;
        // two-flop synchronisers; only the second stage, bit [1], is read by logic
        st_d.lk_sync = {st_q.lk_sync[0], pll_locked_pin};
        st_d.fail_sync = {st_q.fail_sync[0], clock_fail_pin};
        st_d.fail_prev = st_q.fail_sync[1];
        // initial source caught after reset release
        if (!st_q.strap_done) begin
            st_d.strap_done = 1'b1;
            st_d.cur_src    = initial_source_config;
            st_d.new_src    = initial_source_config;
        end
        // pll start-up timer restarts out of lock or off pll
        if (!pll_mode || !st_q.lk_sync[1]) begin
            st_d.pll_cnt = '0;
            st_d.pll_ok  = 1'b0;
        end else if (st_q.pll_cnt >= 16'(PLL_START_CYC - 1)) begin
            st_d.pll_ok  = 1'b1;
        end else begin
            st_d.pll_cnt = st_q.pll_cnt + 16'h0001;
        end
        // software writes, low byte and high byte lanes
        if (wr_hit) begin
            case (avs_address)
                5'(OCCD_OSC_CTRL_OFS): begin
                    if (avs_byteenable[0]) begin
                        st_d.sel_lock = avs_writedata[OCCD_SEL_LOCK_BIT];
                        st_d.sec_drv  = avs_writedata[OCCD_SEC_DRV_BIT];
                        st_d.sec_en   = avs_writedata[OCCD_SEC_EN_BIT];
                        // request a switch unless frozen
                        if (avs_writedata[OCCD_SW_EN_BIT] && !sel_frozen)
                        begin
                            st_d.sw_en = 1'b1;
                        end
                        // fail flag may be cleared by software
                        if (!avs_writedata[OCCD_FAIL_BIT]) begin
                            st_d.fail_flag = 1'b0;
                        end
                    end
                    // new source only while not locked
                    if (avs_byteenable[1] && !sel_frozen
                        && (st_q.state == OCCD_ST_IDLE)) begin
                        st_d.new_src =
                            avs_writedata[OCCD_NEW_SRC_LSB +: 3];
                    end
                end
                5'(OCCD_CLK_DIV_OFS): begin
                    if (avs_byteenable[1]) begin
                        st_d.recover = avs_writedata[OCCD_RECOVER_BIT];
                        st_d.ratio_field_a    = avs_writedata[OCCD_RATIO_FIELD_A_LSB +: 3];
                        st_d.ratio_field_a_en = avs_writedata[OCCD_RATIO_FIELD_A_EN_BIT];
                        st_d.rc_div  = avs_writedata[OCCD_RC_DIV_LSB +: 3];
                    end
                end
                5'(OCCD_IRQ_EN_OFS): begin
                    if (avs_byteenable[0]) begin
                        st_d.en = avs_writedata[OCCD_ST_W-1:0];
                    end
                end
                OCCD_IRQ_CLR_OFS: begin
                    if (avs_byteenable[0]) begin
                        st_d.stat = st_q.stat
                                    & ~avs_writedata[OCCD_ST_W-1:0];
                    end
                end
                default: begin
                    // status and unmapped: write ignored
                end
            endcase
        end
        // failure detected sets the flag, winning over a clear
        if (st_q.fail_sync[1] && !st_q.fail_prev) begin
            st_d.fail_flag = 1'b1;
            ev[OCCD_ST_FAIL_BIT] = 1'b1;
        end
        // interrupt drops ratio_field_a when asked to
        if (cpu_interrupt && st_q.recover && st_q.ratio_field_a_en) begin
            st_d.ratio_field_a_en = 1'b0;
            ev[OCCD_ST_RCVR_BIT] = 1'b1;
        end
        // switch sequencer: settle, load source, clear request
        case (st_q.state)
            OCCD_ST_IDLE: begin
                if (st_q.sw_en) begin
                    st_d.state  = OCCD_ST_SWITCH;
                    st_d.sw_cnt = '0;
                    st_d.pll_ok = 1'b0;
                    st_d.pll_cnt = '0;
                end
            end
            OCCD_ST_SWITCH: begin
                st_d.pll_cnt = '0;
                st_d.pll_ok  = 1'b0;
                if (st_q.sw_cnt >= 4'(OCCD_SWITCH_CYC - 1)) begin
                    st_d.cur_src = st_q.new_src;
                    st_d.state   = OCCD_ST_DONE;
                end else begin
                    st_d.sw_cnt = st_q.sw_cnt + 4'h1;
                end
            end
            OCCD_ST_DONE: begin
                st_d.sw_en = 1'b0;
                st_d.state = OCCD_ST_IDLE;
                ev[OCCD_ST_SWDN_BIT] = 1'b1;
            end
            default: begin
                st_d.state = OCCD_ST_IDLE;
            end
        endcase
        // sticky status: set wins over clear
        st_d.stat = st_d.stat | ev;
        // registered read data
        if (rd_hit) begin
            case (avs_address)
                5'(OCCD_OSC_CTRL_OFS): st_d.rdata = {16'h0000, osc_word};
                5'(OCCD_CLK_DIV_OFS):  st_d.rdata = {16'h0000, div_word};
                5'(OCCD_IRQ_STAT_OFS): st_d.rdata =
                    32'(st_q.stat);
                5'(OCCD_IRQ_EN_OFS):   st_d.rdata = 32'(st_q.en);
                default:               st_d.rdata = 32'h0000_0000;
            endcase
        end
    end
    // state register; reset takes constants only
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q        <= '0;
            st_q.rc_div <= OCCD_RC_DIV_RST;
            st_q.state  <= OCCD_ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end
    // ratio_field_a ratio applies only with ratio_field_a enabled
    assign periph_ratio_shift = st_q.ratio_field_a_en ? {1'b0, st_q.ratio_field_a} : 4'h0;
    // postscaler shift on fast rc sources or low-power rc; rc_post_tick divides on every source
    assign dvi.shift = occd_rc_shift(st_q.rc_div);
    assign rc_post_shift = (st_q.cur_src == OCCD_SRC_FASTRC
                            || st_q.cur_src == OCCD_SRC_FASTRC_PLL
                            || st_q.cur_src == OCCD_SRC_LPRC)
                           ? dvi.shift : 4'h0;
    occd_divider u_div (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .dv      (dvi.div)
    );
    assign rc_post_tick = dvi.tick;
    // secondary oscillator controls
    assign secondary_osc_on = st_q.sec_en;
    assign secondary_osc_high_power = secondary_osc_source_config
                                      && st_q.sec_drv;
    assign current_source_field = st_q.cur_src;
    assign avs_readdata = st_q.rdata;
    assign irq = |(st_q.stat & st_q.en);
endmodule

// file: verif/occd_monitor.sv
// occd_monitor: port-level assertions for the clock control block
// assumes one sys_clk domain; bound onto occd_top at the file foot
`timescale 1ns/100ps
module occd_monitor
    import occd_pkg::*;
#(
    parameter int PLL_START_CYC = 40
)
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        secondary_osc_source_config,
    input wire logic        cpu_interrupt,
    input wire logic        secondary_osc_on,
    input wire logic        secondary_osc_high_power,
    input wire logic [2:0]  current_source_field,
    input wire logic [3:0]  periph_ratio_shift,
    input wire logic [3:0]  rc_post_shift,
    input wire logic        rc_post_tick
);
    logic recover_q; // recover-on-interrupt as software last wrote it
    logic wr_ans; // a write lands in this cycle
    assign wr_ans = avs_write && !avs_waitrequest;
    // shadow of the recovery bit, built from bus writes only
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            recover_q <= 1'b0;
        end else if (wr_ans && avs_address == 5'h04 && avs_byteenable[1]) begin
            recover_q <= avs_writedata[15];
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // exactly one wait cycle before the answer
    sequence s_answer;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // shift held at one long enough for the counter to settle
    sequence s_div2;
        (rc_post_shift == 4'h1)[*3] ##0 rc_post_tick
            ##1 (rc_post_shift == 4'h1)[*2];
    endsequence
    property p_answer;
        ($rose(avs_read) || $rose(avs_write)) |-> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("bad wait count");
    property p_idle;
        !avs_read && !avs_write |-> !avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("wait with no request");
    property p_pll_off;
        avs_read && !avs_waitrequest && avs_address == 5'h00
            && current_source_field != OCCD_SRC_FASTRC_PLL
            |-> !avs_readdata[5];
    endproperty
    a_pll_off: assert property (p_pll_off)
        else $error("lock off pll");
    property p_sec_on;
        wr_ans && avs_address == 5'h00 && avs_byteenable[0]
            |=> secondary_osc_on == $past(avs_writedata[1]);
    endproperty
    a_sec_on: assert property (p_sec_on) else $error("osc enable");
    property p_hp_dig;
        !secondary_osc_source_config |-> !secondary_osc_high_power;
    endproperty
    a_hp_dig: assert property (p_hp_dig) else $error("drive moot");
    property p_ratio_field_a;
        wr_ans && avs_address == 5'h04 && avs_byteenable[1] && !cpu_interrupt
            |=> periph_ratio_shift == ($past(avs_writedata[11]) ?
                {1'b0, $past(avs_writedata[14:12])} : 4'h0);
    endproperty
    a_ratio_field_a: assert property (p_ratio_field_a)
        else $error("ratio_field_a ratio");
    property p_recover;
        cpu_interrupt && recover_q && !avs_write
            |-> ##[1:3] periph_ratio_shift == 4'h0;
    endproperty
    a_recover: assert property (p_recover)
        else $error("no recovery");
    property p_tick;
        s_div2 |-> rc_post_tick && !$past(rc_post_tick);
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing");
endmodule

bind occd_top occd_monitor #(.PLL_START_CYC(PLL_START_CYC)) u_mon (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .secondary_osc_source_config(secondary_osc_source_config),
    .cpu_interrupt(cpu_interrupt), .secondary_osc_on(secondary_osc_on),
    .secondary_osc_high_power(secondary_osc_high_power),
    .current_source_field(current_source_field),
    .periph_ratio_shift(periph_ratio_shift),
    .rc_post_shift(rc_post_shift), .rc_post_tick(rc_post_tick)
);

// file: verif/testbench.sv
// testbench: register-level tests of the clock control block
// assumes occd_top on an avalon-mm bus with occd_monitor bound to it
`timescale 1ns/100ps
module testbench
    import occd_pkg::*;
;
    localparam int PLL_CYC = 4; // short start-up timer keeps runs brief
    logic        sys_clk, reset_n;            // clock and reset
    logic [4:0]  avs_address;                 // bus address
    logic        avs_read, avs_write;         // bus strobes
    logic [31:0] avs_writedata, avs_readdata; // bus data
    logic [3:0]  avs_byteenable;              // byte lanes
    logic        avs_waitrequest;             // slave stall
    logic        fs_cfg, src_cfg, pll_pin;    // config and lock pins
    logic        fail_pin, cpu_int;           // event pins
    logic [2:0]  init_src, cur_src;           // sources
    logic        sec_on, sec_hp, irq, tick;   // outputs
    logic [3:0]  ratio, rc_shift;             // divide exponents
    int          errors, n_checks;            // tallies
    occd_top #(.PLL_START_CYC(PLL_CYC)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .failsafe_monitor_config_bit(fs_cfg),
        .secondary_osc_source_config(src_cfg),
        .initial_source_config(init_src), .pll_locked_pin(pll_pin),
        .clock_fail_pin(fail_pin), .cpu_interrupt(cpu_int),
        .secondary_osc_on(sec_on), .secondary_osc_high_power(sec_hp),
        .current_source_field(cur_src), .periph_ratio_shift(ratio),
        .rc_post_shift(rc_shift), .rc_post_tick(tick), .irq(irq)
    );
    // 50 ns period
    always #25 sys_clk = ~sys_clk;
    // compare and tally
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one transfer held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) errors++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk); // strobe low for a cycle between transfers
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, {16'h0, d}, q);
    endtask
    // read and compare the masked bits
    task automatic rd(input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q & m, exp);
    endtask
    task automatic pulse();
        cpu_int <= 1'b1;
        cyc(1);
        cpu_int <= 1'b0;
        cyc(3);
    endtask
    task automatic end_of_test();
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        {avs_read, avs_write, cpu_int, fs_cfg, pll_pin, fail_pin} = 6'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        src_cfg = 1'b1;
        init_src = OCCD_SRC_FASTRC;
        errors = 0;
        n_checks = 0;
        cyc(8);
        reset_n <= 1'b1;
        cyc(2);
        rd(5'h00, 32'hffff_ffff, 32'h0000_7700);
        rd(5'h04, 32'hffff_ffff, {16'h0, OCCD_CLK_DIV_RST});
        for (int i = 0; i < 8; i++) begin
            wr(5'h04, 16'(i << 8));
            cyc(6);
            check({28'h0, rc_shift}, (i == 7) ? 32'h8 : 32'(i));
        end
        for (int i = 0; i < 8; i++) begin
            wr(5'h04, 16'h0800 | 16'(i << 12));
            check({28'h0, ratio}, 32'(i));
            wr(5'h04, 16'(i << 12));
            check({28'h0, ratio}, 32'h0);
        end
        wr(5'h04, 16'hb800);
        pulse();
        check({28'h0, ratio}, 32'h0);
        rd(5'h04, 32'h0800, 32'h0);
        wr(5'h04, 16'h3800);
        pulse();
        check({28'h0, ratio}, 32'h3);
        rd(5'h04, 32'h0800, 32'h0800);
        wr(5'h00, 16'h0706);
        check({30'h0, sec_on, sec_hp}, 32'h3);
        src_cfg <= 1'b0;
        cyc(1);
        check({31'h0, sec_hp}, 32'h0);
        src_cfg <= 1'b1;
        wr(5'h00, 16'h0702);
        check({30'h0, sec_on, sec_hp}, 32'h2);
        wr(5'h00, 16'h0700);
        check({31'h0, sec_on}, 32'h0);
        wr(5'h00, 16'h0601);
        cyc(10);
        check({29'h0, cur_src}, 32'h6);
        rd(5'h00, 32'h7701, 32'h6600);
        wr(5'h04, 16'h0200);
        check({28'h0, rc_shift}, 32'h2);
        wr(5'h04, 16'h0700);
        check({28'h0, rc_shift}, 32'h8);
        fs_cfg <= 1'b1;
        wr(5'h00, 16'h0680);
        wr(5'h00, 16'h0181);
        cyc(10);
        check({29'h0, cur_src}, 32'h6);
        fs_cfg <= 1'b0;
        wr(5'h00, 16'h0181);
        cyc(10);
        check({29'h0, cur_src}, 32'h1);
        pll_pin <= 1'b1;
        cyc(PLL_CYC + 8);
        rd(5'h00, 32'h20, 32'h20);
        pll_pin <= 1'b0;
        cyc(6);
        rd(5'h00, 32'h20, 32'h0);
        pll_pin <= 1'b1;
        wr(5'h00, 16'h0781);
        rd(5'h00, 32'h20, 32'h0);
        cyc(PLL_CYC + 8);
        rd(5'h00, 32'h20, 32'h0);
        fail_pin <= 1'b1;
        cyc(4);
        fail_pin <= 1'b0;
        cyc(4);
        rd(5'h00, 32'h8, 32'h8);
        check({31'h0, irq}, 32'h0);
        wr(5'h0c, 16'h0001);
        check({31'h0, irq}, 32'h1);
        rd(5'h0c, 32'h7, 32'h1);
        wr(5'h10, 16'h0001);
        check({31'h0, irq}, 32'h0);
        rd(5'h08, 32'h7, 32'h6);
        // unmapped place reads zero and swallows writes
        rd(5'h14, 32'hffff_ffff, 32'h0);
        wr(5'h14, 16'hffff);
        rd(5'h04, 32'hffff_ffff, 32'h0700);
        end_of_test();
    end
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        errors++;
        end_of_test();
    end
endmodule
